// ==== shared/cie_pkg.sv ====
package cie_pkg;
  // Datapath and memory geometry
  localparam int DATA_W      = 25;
  localparam int ADDR_W      = 6;
  localparam int PC_W        = 8;
  localparam int CDR_W       = 9;
  localparam int SIGN_POS    = 8;
  localparam int CYC_PER_INS = 4;
  localparam int PROG_LEN    = 192;
  localparam int GROUP       = 4;
  // Field positions of the instruction word
  localparam int OP_LSB      = 0;
  localparam int SH_LSB      = 3;
  localparam int SRC_LSB     = 7;
  localparam int DST_LSB     = 13;
  localparam int IO_LSB      = 19;
  localparam int INS_W       = 24;

  typedef enum logic [2:0] {
    CIE_OP_ADD = 3'h0,
    CIE_OP_LDA = 3'h1,
    CIE_OP_SUB = 3'h2,
    CIE_OP_ABA = 3'h3,
    CIE_OP_XOR = 3'h4,
    CIE_OP_ABS = 3'h5,
    CIE_OP_AND = 3'h6,
    CIE_OP_LIM = 3'h7
  } cie_op_type;

  // Iocode groups: 0 nop, 1..9 conditional (1 = sign), 10..18 conversion steps, 19 end
  localparam logic [4:0] IO_NOP      = 5'h00;
  localparam logic [4:0] IO_CND_SIGN = 5'h01;
  localparam logic [4:0] IO_CND_B0   = 5'h02;
  localparam logic [4:0] IO_CVT_SIGN = 5'h0A;
  localparam logic [4:0] IO_CVT_B0   = 5'h0B;
  localparam logic [4:0] IO_END      = 5'h13;

  // Shift codes: 0 none, 1..13 right 1..13, 14,15 left 1,2
  localparam logic [3:0] SH_NONE     = 4'h0;
  localparam logic [3:0] SH_L1       = 4'hE;
  localparam logic [3:0] SH_L2       = 4'hF;

  typedef struct packed {
    logic [4:0]        io;
    logic [ADDR_W-1:0] dst;
    logic [ADDR_W-1:0] src;
    logic [3:0]        sh;
    cie_op_type        op;
  } cie_instr_type;
endpackage : cie_pkg

// ==== logic/cie_shifter.sv ====
`timescale 1ns/100ps
`default_nettype none
// Source operand shifter; right shifts fill with the sign
module cie_shifter #(
  parameter int W = cie_pkg::DATA_W
) (
  input  wire logic [W-1:0] i_val,
  input  wire logic [3:0]   i_code,
  output logic      [W-1:0] o_val
);
  // Code zero passes the source untouched
  always_comb begin
    case (i_code)
      cie_pkg::SH_NONE: o_val = i_val;
      cie_pkg::SH_L1:   o_val = {i_val[W-2:0], 1'b0};
      cie_pkg::SH_L2:   o_val = {i_val[W-3:0], 2'b00};
      default:          o_val = W'($signed(i_val) >>> i_code);
    endcase
  end
endmodule : cie_shifter
`default_nettype wire

// ==== logic/cie_core.sv ====
`timescale 1ns/100ps
`default_nettype none
module cie_core #(
  parameter int DW       = cie_pkg::DATA_W,
  parameter int PROG_LEN = cie_pkg::PROG_LEN
) (
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rst_b,
  input  wire logic [cie_pkg::INS_W-1:0]  i_instr,
  input  wire logic                       i_comparator,
  output logic      [cie_pkg::PC_W-1:0]   o_fetch_addr,
  output logic      [cie_pkg::CDR_W-1:0]  o_conversion_data_register,
  output logic                            o_carry,
  output logic                            o_limit_en,
  output logic                            o_overflow,
  output logic                            o_instr_done
);
  localparam logic [cie_pkg::PC_W-1:0] LAST_ADDR = cie_pkg::PC_W'(PROG_LEN - 1);

  logic [1:0]                 phase;
  logic [cie_pkg::PC_W-1:0]   pc;
  logic                       wrap_pend;
  cie_pkg::cie_instr_type     ins;
  logic [DW-1:0]              ram [0:(1<<cie_pkg::ADDR_W)-1];
  logic [DW-1:0]              src_sh;
  logic [DW-1:0]              dst_v;
  logic [DW-1:0]              next_res;
  logic                       next_carry;
  logic                       next_ovf;
  logic                       cond_bit;
  logic                       is_cnd;
  logic                       is_cvt;
  logic [3:0]                 sel;
  logic                       exec;

  // Number of the bit a conditional or conversion code names
  function automatic logic [3:0] bit_sel(input logic [4:0] io, input logic [4:0] base);
    if (io == base) begin
      bit_sel = 4'(cie_pkg::SIGN_POS);
    end else begin
      bit_sel = 4'(io - base - 5'h01);
    end
  endfunction : bit_sel

  assign ins    = cie_pkg::cie_instr_type'(i_instr);
  assign exec   = (phase == 2'(cie_pkg::CYC_PER_INS - 1));
  assign is_cnd = (ins.io >= cie_pkg::IO_CND_SIGN) && (ins.io < cie_pkg::IO_CVT_SIGN);
  assign is_cvt = (ins.io >= cie_pkg::IO_CVT_SIGN) && (ins.io < cie_pkg::IO_END);
  assign sel    = is_cnd ? bit_sel(ins.io, cie_pkg::IO_CND_SIGN)
                         : bit_sel(ins.io, cie_pkg::IO_CVT_SIGN);
  assign cond_bit = o_conversion_data_register[sel];
  assign dst_v    = ram[ins.dst];
  assign o_fetch_addr = pc;
  assign o_instr_done = exec;

  // Shifter ahead of the adder; code zero gives a straight pass
  cie_shifter #(.W(DW)) u_shift (
    .i_val  (ram[ins.src]),
    .i_code (ins.sh),
    .o_val  (src_sh)
  );

  // ALU; only add, load and subtract honour a condition
  always_comb begin
    logic [DW:0] sum;
    sum        = '0;
    next_res   = dst_v;
    next_carry = 1'b0;
    next_ovf   = 1'b0;
    case (ins.op)
      cie_pkg::CIE_OP_ADD: begin
        sum = {1'b0, dst_v} + {1'b0, ((is_cnd && !cond_bit) ? {DW{1'b0}} : src_sh)};
        next_res   = sum[DW-1:0];
        next_carry = sum[DW];
        next_ovf   = (dst_v[DW-1] == src_sh[DW-1]) && (sum[DW-1] != dst_v[DW-1]) &&
                     !(is_cnd && !cond_bit);
      end
      cie_pkg::CIE_OP_LDA: begin
        next_res   = (is_cnd && !cond_bit) ? dst_v : src_sh;
        next_carry = 1'b0;
      end
      cie_pkg::CIE_OP_SUB: begin
        if (is_cnd && !o_carry) begin
          sum = {1'b0, dst_v} + {1'b0, src_sh};
        end else begin
          sum = {1'b0, dst_v} + {1'b0, ~src_sh} + (DW+1)'(1);
        end
        next_res   = sum[DW-1:0];
        next_carry = sum[DW];
        next_ovf   = (sum[DW-1] != dst_v[DW-1]) &&
                     (dst_v[DW-1] == (sum == ({1'b0, dst_v} + {1'b0, src_sh}) ?
                                      src_sh[DW-1] : ~src_sh[DW-1]));
      end
      cie_pkg::CIE_OP_ABA: begin
        sum = {1'b0, dst_v} + {1'b0, (src_sh[DW-1] ? DW'(-src_sh) : src_sh)};
        next_res   = sum[DW-1:0];
        next_carry = sum[DW];
        next_ovf   = !dst_v[DW-1] && sum[DW-1];
      end
      cie_pkg::CIE_OP_XOR: next_res = dst_v ^ src_sh;
      cie_pkg::CIE_OP_ABS: next_res = src_sh[DW-1] ? DW'(-src_sh) : src_sh;
      cie_pkg::CIE_OP_AND: next_res = dst_v & src_sh;
      cie_pkg::CIE_OP_LIM: next_res = ram[ins.src][DW-1] ? {1'b1, {(DW-1){1'b0}}}
                                                         : {1'b0, {(DW-1){1'b1}}};
      default:             next_res = dst_v;
    endcase
  end

  // Four clocks per instruction
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Fetch counter; after an end code, runs on through the next last slot of a group of four, then wraps
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      pc        <= '0;
      wrap_pend <= 1'b0;
    end else if (exec) begin
      if (ins.io == cie_pkg::IO_END) begin
        wrap_pend <= 1'b1;
        pc        <= pc + cie_pkg::PC_W'(1);
      end else if (wrap_pend && (pc[1:0] == 2'(cie_pkg::GROUP - 1))) begin
        pc        <= '0;
        wrap_pend <= 1'b0;
      end else if (pc == LAST_ADDR) begin
        pc        <= '0;
      end else begin
        pc        <= pc + cie_pkg::PC_W'(1);
      end
    end
  end

  // Destination write-back and overflow saturation; data words clear at
  // reset so a pass never starts from unknown operands or an unknown carry
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      for (int a = 0; a < (1 << cie_pkg::ADDR_W); a++) begin
        ram[a] <= '0;
      end
    end else if (exec) begin
      if (next_ovf && o_limit_en) begin
        ram[ins.dst] <= dst_v[DW-1] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
      end else begin
        ram[ins.dst] <= next_res;
      end
    end
  end

  // Carry flag of the latest operation
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_carry    <= 1'b0;
      o_overflow <= 1'b0;
    end else if (exec) begin
      o_carry    <= next_carry;
      o_overflow <= next_ovf;
    end
  end

  // Limiting control; an end code wins as it is the pass boundary
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_limit_en <= 1'b1;
    end else if (exec) begin
      if (ins.io == cie_pkg::IO_END) begin
        o_limit_en <= 1'b1;
      end else if (is_cnd && ins.op == cie_pkg::CIE_OP_ABA) begin
        o_limit_en <= 1'b0;
      end else if (is_cnd && ins.op == cie_pkg::CIE_OP_XOR) begin
        o_limit_en <= 1'b1;
      end
    end
  end

  // Conversion register: trial bits, decisions and conditional-subtract carry.
  // Settling between steps is the program's job; no interlock here.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_conversion_data_register <= '0;
    end else if (exec) begin
      if (is_cvt) begin
        o_conversion_data_register[sel] <= i_comparator;
        if (sel != 4'h0) begin
          o_conversion_data_register[sel - 4'h1] <= 1'b1;
        end
      end else if (is_cnd && ins.op == cie_pkg::CIE_OP_SUB) begin
        o_conversion_data_register[sel] <= next_carry;
      end
    end
  end
endmodule : cie_core
`default_nettype wire

// ==== dv/cie_prog_store.sv ====
`timescale 1ns/100ps
`default_nettype none
// Program store; no kinder than a real one
module cie_prog_store (
  input  wire logic [cie_pkg::PC_W-1:0]  i_addr,
  input  wire logic                      i_done,
  output logic      [cie_pkg::INS_W-1:0] o_word
);
  cie_pkg::cie_instr_type mem [256];
  // Word inverted outside the take cycle, so early sampling shows up
  assign o_word = i_done ? mem[i_addr] : ~mem[i_addr];
endmodule : cie_prog_store
`default_nettype wire

// ==== dv/cie_core_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module cie_core_properties (
  input wire logic                      i_ref_clk,
  input wire logic                      i_rst_b,
  input wire logic [cie_pkg::INS_W-1:0] i_instr,
  input wire logic                      i_comparator,
  input wire logic [cie_pkg::PC_W-1:0]  o_fetch_addr,
  input wire logic [cie_pkg::CDR_W-1:0] o_conversion_data_register,
  input wire logic                      o_carry,
  input wire logic                      o_limit_en,
  input wire logic                      o_overflow,
  input wire logic                      o_instr_done
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  logic [4:0] io;
  logic [2:0] op;
  logic [3:0] tbit;
  logic [3:0] sbit;
  logic       is_cond;
  logic       is_step;
  // Decode of the taken word; both bit indices put the sign at 8
  assign io      = i_instr[cie_pkg::IO_LSB +: 5];
  assign op      = i_instr[2:0];
  assign is_cond = o_instr_done && io >= 5'h01 && io <= 5'h09;
  assign is_step = o_instr_done && io >= 5'h0A && io <= 5'h12;
  assign tbit    = (io == 5'h01) ? 4'h8 : 4'(io - 5'h02);
  assign sbit    = (io == 5'h0A) ? 4'h8 : 4'(io - 5'h0B);
  // End code, then three more taken words at four-clock spacing
  sequence s_end_taken;
    o_instr_done && io == cie_pkg::IO_END;
  endsequence
  sequence s_three_more;
    ##4 o_instr_done ##4 o_instr_done ##4 o_instr_done;
  endsequence
  a_period_four: assert property (o_instr_done |=> !o_instr_done [*3] ##1 o_instr_done)
    else $error("instruction period not four clocks");
  a_state_hold: assert property (!o_instr_done |=> $stable(o_fetch_addr) && $stable(o_carry))
    else $error("state moved between execute edges");
  a_end_wrap: assert property (s_end_taken |-> s_three_more ##1 o_fetch_addr == 8'h00)
    else $error("no return to location zero");
  a_end_limit: assert property (s_end_taken |=> o_limit_en)
    else $error("end code left limiting off");
  a_aba_unlimit: assert property (is_cond && op == cie_pkg::CIE_OP_ABA |=> !o_limit_en)
    else $error("conditional absolute add kept limiting");
  a_xor_relimit: assert property (is_cond && op == cie_pkg::CIE_OP_XOR |=> o_limit_en)
    else $error("conditional xor left limiting off");
  a_load_carry: assert property (o_instr_done && op == cie_pkg::CIE_OP_LDA |=> !o_carry)
    else $error("load produced a carry");
  a_supp_clear: assert property (is_cond && !o_conversion_data_register[tbit] &&
    (op == cie_pkg::CIE_OP_ADD || op == cie_pkg::CIE_OP_LDA) |=> !o_carry)
    else $error("suppressed operation kept carry");
  a_step_decide: assert property (is_step |=>
    o_conversion_data_register[$past(sbit)] == $past(i_comparator))
    else $error("step bit differs from comparator");
  a_step_trial: assert property (is_step && io != cie_pkg::IO_CVT_B0 |=>
    o_conversion_data_register[$past(sbit) - 4'h1])
    else $error("trial bit not set");
  a_sub_store: assert property (is_cond && op == cie_pkg::CIE_OP_SUB |=>
    o_conversion_data_register[$past(tbit)] == o_carry)
    else $error("subtract carry not stored");
endmodule : cie_core_properties
bind cie_core cie_core_properties u_cie_core_properties (.i_ref_clk, .i_rst_b, .i_instr,
  .i_comparator, .o_fetch_addr, .o_conversion_data_register, .o_carry, .o_limit_en,
  .o_overflow, .o_instr_done);
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic                      i_ref_clk    = 1'b0;
  logic                      i_rst_b      = 1'b0;
  logic                      i_comparator = 1'b0;
  logic [cie_pkg::INS_W-1:0] i_instr;
  logic [cie_pkg::PC_W-1:0]  o_fetch_addr;
  logic [cie_pkg::CDR_W-1:0] o_cdr;
  logic                      o_carry;
  logic                      o_limit_en;
  logic                      o_instr_done;
  logic                      o_overflow;
  int                        n_mismatch  = 0;
  int                        check_count = 0;
  int                        cycles      = 0;
  cie_prog_store u_cie_prog_store (.i_addr(o_fetch_addr), .i_done(o_instr_done), .o_word(i_instr));
  cie_core u_cie_core (.i_ref_clk, .i_rst_b, .i_instr, .i_comparator, .o_fetch_addr,
    .o_conversion_data_register(o_cdr), .o_carry, .o_limit_en, .o_overflow, .o_instr_done);
  // Clock and a hang limit well above the few hundred cycles needed
  always #50 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles > 3000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic cie_pkg::cie_instr_type w(cie_pkg::cie_op_type op, logic [4:0] io);
    return '{io, 6'h01, 6'h02, cie_pkg::SH_NONE, op};
  endfunction : w
  // Fill with idle loads; a mid-run reset restarts the pass
  task automatic restart(input bit fill);
    for (int a = 0; a < 256 && fill; a++) u_cie_prog_store.mem[a] = w(cie_pkg::CIE_OP_LDA, 5'h00);
    @(posedge i_ref_clk) i_rst_b <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
  endtask : restart
  // Run n instructions; returns just after the last execute edge
  task automatic exec(input int n);
    repeat (n) begin
      wait (o_instr_done === 1'b1);
      @(posedge i_ref_clk);
      #1;
    end
  endtask : exec
  task automatic t_convert();
    logic [8:0] p;
    p = 9'h1A5;
    restart(1'b1);
    // Steps on alternate slots with arithmetic beside them, end on a four boundary
    for (int i = 0; i < 9; i++) u_cie_prog_store.mem[2*i] =
      w(cie_pkg::CIE_OP_ADD, (i == 0) ? cie_pkg::IO_CVT_SIGN : 5'(cie_pkg::IO_CVT_B0 + 8 - i));
    u_cie_prog_store.mem[19] = w(cie_pkg::CIE_OP_ABA, cie_pkg::IO_CND_SIGN);
    u_cie_prog_store.mem[20] = w(cie_pkg::CIE_OP_LDA, cie_pkg::IO_END);
    restart(1'b0);
    for (int i = 0; i < 9; i++) begin
      @(posedge i_ref_clk) i_comparator <= p[8-i];
      exec(1);
      if (i == 0) check(o_cdr[8:7], {p[8], 1'b1});
      exec(1);
    end
    check(o_cdr, p);
    exec(2);
    check(o_limit_en, 1'b0);
    exec(1);
    check(o_limit_en, 1'b1);
    check(o_fetch_addr, 8'h15);
    exec(3);
    check(o_fetch_addr, 8'h00);
    $display("test convert done");
  endtask : t_convert
  task automatic t_cond();
    restart(1'b1);
    // Data is zero after reset, so a plain subtract of equal words sets the carry;
    // every test bit is clear, so each conditional case must clear it again
    for (int c = 0; c < 9; c++) begin
      u_cie_prog_store.mem[4*c]   = w(cie_pkg::CIE_OP_SUB, 5'h00);
      u_cie_prog_store.mem[4*c+1] = w(cie_pkg::CIE_OP_ADD, 5'(cie_pkg::IO_CND_SIGN + c));
      u_cie_prog_store.mem[4*c+2] = w(cie_pkg::CIE_OP_SUB, 5'h00);
      u_cie_prog_store.mem[4*c+3] = w(cie_pkg::CIE_OP_LDA, 5'(cie_pkg::IO_CND_SIGN + c));
    end
    u_cie_prog_store.mem[36] = w(cie_pkg::CIE_OP_SUB, cie_pkg::IO_CND_B0);
    u_cie_prog_store.mem[37] = w(cie_pkg::CIE_OP_ABA, cie_pkg::IO_CND_B0);
    u_cie_prog_store.mem[38] = w(cie_pkg::CIE_OP_XOR, cie_pkg::IO_CND_SIGN);
    u_cie_prog_store.mem[40] = w(cie_pkg::CIE_OP_SUB, 5'h00);
    u_cie_prog_store.mem[41] = w(cie_pkg::CIE_OP_SUB, cie_pkg::IO_CND_B0);
    restart(1'b0);
    for (int k = 0; k < 18; k++) begin
      exec(2);
      check(o_carry, 1'b0);
      check(o_overflow, 1'b0);
    end
    // Carry clear before it: operands add, so a zero carry lands in bit 0
    exec(1);
    check({o_cdr[0], o_carry}, 2'h0);
    exec(1);
    check(o_limit_en, 1'b0);
    exec(1);
    check(o_limit_en, 1'b1);
    exec(1);
    check(o_carry, 1'b0);
    // Carry set before it: operands subtract, so the carry out lands in bit 0
    exec(2);
    check({o_cdr[0], o_carry}, 2'h3);
    check(o_overflow, 1'b0);
    $display("test conditional done");
  endtask : t_cond
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    #1;
    check({o_fetch_addr, o_carry, o_limit_en, o_overflow}, 16'h0002);
    $display("test reset done");
    t_convert();
    t_cond();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
